/* src/hlk_chk_walk.sv */
// checksum walker: sums bytes 0..510 of the selected sector
// assumes the caller returns the byte at walk_idx in the same cycle
`timescale 1ns/1ps
module hlk_chk_walk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] byte_in,
  output logic busy,
  output logic [8:0] walk_idx,
  output logic [7:0] checksum
);
  import hlk_pkg::*;

  logic busy_q; // walk in progress
  logic [8:0] idx_q; // byte now summed
  logic [7:0] sum_q; // running modulo-256 sum

  // walk one byte per enabled cycle; a restart mid-walk starts over
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      idx_q <= 9'h000;
      sum_q <= 8'h00;
    end else if (ce) begin
      if (start) begin
        busy_q <= 1'b1;
        idx_q <= 9'h000;
        sum_q <= 8'h00;
      end else if (busy_q) begin
        sum_q <= sum_q + byte_in;
        if (idx_q == 9'(HLK_SECTOR_LAST - 1)) begin
          busy_q <= 1'b0;
        end else begin
          idx_q <= idx_q + 9'h001;
        end
      end
    end
  end

  assign busy = busy_q;
  assign walk_idx = idx_q;
  // two's complement so the full sector sums to zero
  assign checksum = 8'(~sum_q + 8'h01);
endmodule

/* src/hlk_keeper.sv */
// health log sector keeper: stores the error and self-test logs and
// serves log sectors byte by byte over apb.
// assumes firmware stages records over apb; fail pins are asynchronous.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module hlk_keeper (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic attr_rd_fail,
  input wire logic attr_wr_fail,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);
  import hlk_pkg::*;
  localparam int ERR_BYTES = HLK_ERR_RECS * HLK_REC_BYTES;
  // apb answer flops
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  // software-written settings
  logic [7:0] log_sel_q; // log address to serve
  logic [8:0] rd_idx_q; // byte offset to read
  logic [3:0] dstate_q; // device state code
  logic [3:0] dvend_q; // vendor nibble of state byte
  logic [15:0] poh_q; // power-on hours now
  logic [7:0] std_num_q; // staged self-test number
  logic [7:0] std_stat_q; // staged execution status
  logic [7:0] std_cp_q; // staged failure checkpoint
  logic [31:0] std_lba_q; // staged first failing lba
  logic [7:0] cmd_sts_q; // last health command status
  logic [7:0] cmd_err_q; // last health command error
  logic health_en_q; // health monitoring enabled
  // log storage
  logic [7:0] stage_q [0:HLK_REC_BYTES-1]; // staged error record
  logic [7:0] err_mem_q [0:ERR_BYTES-1]; // five error records
  logic [2:0] err_ptr_q; // newest error record
  logic [15:0] err_cnt_q; // total errors seen
  logic [7:0] st_num_q [0:HLK_ST_DESCS-1], st_stat_q [0:HLK_ST_DESCS-1];
  logic [15:0] st_poh_q [0:HLK_ST_DESCS-1];
  logic [7:0] st_cp_q [0:HLK_ST_DESCS-1];
  logic [31:0] st_lba_q [0:HLK_ST_DESCS-1];
  logic [4:0] st_ptr_q; // newest descriptor, 0 when empty
  // fail pin synchronisers
  logic [1:0] rdf_sync_q, wrf_sync_q;
  // apb decode; a request is taken once, in its first access cycle
  logic access, wr_acc, mapped;
  assign access = psel && penable && !pready_q;
  assign wr_acc = access && pwrite;
  always_comb begin
    case (paddr)
      HLK_A_CTRL, HLK_A_LOGSEL, HLK_A_RDIDX, HLK_A_RDDATA, HLK_A_STAGE,
      HLK_A_DSTATE, HLK_A_POH, HLK_A_STDESC, HLK_A_STLBA, HLK_A_CMD,
      HLK_A_INFO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // ctrl strobes, each one write wide
  logic commit_err, commit_st, assemble, cmd_wr;
  assign commit_err = wr_acc && paddr == HLK_A_CTRL && pwdata[HLK_B_COMMIT_ERR];
  assign commit_st = wr_acc && paddr == HLK_A_CTRL && pwdata[HLK_B_COMMIT_ST];
  assign assemble = wr_acc && paddr == HLK_A_CTRL && pwdata[HLK_B_ASSEMBLE];
  assign cmd_wr = wr_acc && paddr == HLK_A_CMD;
  // checksum walker shares the byte mux with apb reads
  logic walk_busy;
  logic [8:0] walk_idx;
  logic [7:0] checksum;
  logic [7:0] mux_byte;
  hlk_chk_walk u_walk (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .start(assemble || (wr_acc && paddr == HLK_A_LOGSEL)),
    .byte_in(mux_byte),
    .busy(walk_busy),
    .walk_idx(walk_idx),
    .checksum(checksum)
  );
  // record slot holding a summary offset; loop avoids a divider
  function automatic int rec_of(input logic [8:0] o);
    int r;
    r = 0;
    for (int k = 1; k < HLK_ERR_RECS; k++) begin
      if (int'(o) >= int'(HLK_OFS_REC0) + k * HLK_REC_BYTES) r = k;
    end
    return r;
  endfunction
  // descriptor slot holding a self-test offset
  function automatic int desc_of(input logic [8:0] o);
    int n;
    n = 0;
    for (int k = 1; k < HLK_ST_DESCS; k++) begin
      if (int'(o) >= int'(HLK_OFS_DESC0) + k * HLK_ST_BYTES) n = k;
    end
    return n;
  endfunction
  // sector count for each log address
  function automatic logic [7:0] dir_count(input logic [7:0] a);
    if (a == HLK_LOG_SUMMARY || a == HLK_LOG_SELFTEST) return 8'h01;
    if (a >= HLK_LOG_HOST_LO && a <= HLK_LOG_HOST_HI) return HLK_HOST_LOG_SECTORS;
    return 8'h00;
  endfunction
  // byte of the selected sector at offset mo
  logic [8:0] mo;
  assign mo = walk_busy ? walk_idx : rd_idx_q;
  always_comb begin
    int r, n, f;
    r = 0;
    n = 0;
    f = 0;
    mux_byte = 8'h00;
    case (log_sel_q)
      HLK_LOG_DIR: begin
        if (mo == 9'h000) begin
          mux_byte = HLK_LOG_VERSION;
        end else if (mo >= 9'h002 && !mo[0]) begin
          mux_byte = dir_count(mo[8:1]);
        end
      end
      HLK_LOG_SUMMARY: begin
        if (mo == 9'h000) begin
          mux_byte = HLK_LOG_VERSION;
        end else if (mo == 9'h001) begin
          mux_byte = {5'h00, err_ptr_q};
        end else if (mo < HLK_OFS_ERRCNT) begin
          r = rec_of(mo);
          f = int'(mo) - int'(HLK_OFS_REC0) - r * HLK_REC_BYTES;
          mux_byte = err_mem_q[r * HLK_REC_BYTES + f];
        end else if (mo == HLK_OFS_ERRCNT) begin
          mux_byte = err_cnt_q[7:0];
        end else if (mo == HLK_OFS_ERRCNT + 9'h001) begin
          mux_byte = err_cnt_q[15:8];
        end
      end
      HLK_LOG_SELFTEST: begin
        if (mo == 9'h000) begin
          mux_byte = HLK_ST_REV;
        end else if (mo == HLK_OFS_STPTR) begin
          mux_byte = {3'h0, st_ptr_q};
        end else if (mo >= HLK_OFS_DESC0 &&
                     int'(mo) < int'(HLK_OFS_DESC0) + HLK_ST_DESCS * HLK_ST_BYTES) begin
          n = desc_of(mo);
          f = int'(mo) - int'(HLK_OFS_DESC0) - n * HLK_ST_BYTES;
          case (f)
            0: mux_byte = st_num_q[n];
            1: mux_byte = st_stat_q[n];
            2: mux_byte = st_poh_q[n][7:0];
            3: mux_byte = st_poh_q[n][15:8];
            4: mux_byte = st_cp_q[n];
            5: mux_byte = st_lba_q[n][7:0];
            6: mux_byte = st_lba_q[n][15:8];
            7: mux_byte = st_lba_q[n][23:16];
            8: mux_byte = st_lba_q[n][31:24];
            default: mux_byte = 8'h00; // vendor bytes read zero
          endcase
        end
      end
      default: mux_byte = 8'h00; // host logs and unused logs are blank
    endcase
  end
  // byte served at the checksum position is the walker's checksum from the last log select write or assemble strobe
  logic [7:0] rd_byte;
  assign rd_byte = (rd_idx_q == HLK_OFS_CHECKSUM) ? checksum : mux_byte;
  // state byte: reserved codes fall back to unknown
  logic [3:0] state_code;
  assign state_code = (dstate_q > HLK_STATE_OFFLINE && dstate_q < HLK_STATE_VEND_LO)
                      ? HLK_STATE_UNKNOWN : dstate_q;
  // staged record with hardware-owned snapshot fields patched in
  logic [7:0] rec_byte [0:HLK_REC_BYTES-1];
  genvar gi;
  generate
    for (gi = 0; gi < HLK_REC_BYTES; gi++) begin : g_rec
      if (gi == HLK_OFS_ESNAP + HLK_OFS_STATE) begin : g_state
        assign rec_byte[gi] = {dvend_q, state_code};
      end else if (gi == HLK_OFS_ESNAP + HLK_OFS_LIFE) begin : g_poh_lo
        assign rec_byte[gi] = poh_q[7:0];
      end else if (gi == HLK_OFS_ESNAP + HLK_OFS_LIFE + 1) begin : g_poh_hi
        assign rec_byte[gi] = poh_q[15:8];
      end else begin : g_raw
        // command snapshots carry registers then ms stamp as staged
        assign rec_byte[gi] = stage_q[gi];
      end
    end
  endgenerate
  // next error slot wraps from five back to one
  logic [2:0] err_next;
  assign err_next = (err_ptr_q == 3'(HLK_ERR_RECS)) ? 3'h1 : err_ptr_q + 3'h1;
  // next self-test slot wraps after the last descriptor
  logic [4:0] st_next;
  assign st_next = (st_ptr_q == 5'(HLK_ST_DESCS)) ? 5'h01 : st_ptr_q + 5'h01;
  // fail pins arrive from another domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdf_sync_q <= 2'h0;
      wrf_sync_q <= 2'h0;
    end else if (ce) begin
      rdf_sync_q <= {rdf_sync_q[0], attr_rd_fail};
      wrf_sync_q <= {wrf_sync_q[0], attr_wr_fail};
    end
  end
  // apb answer: one wait cycle so read data comes from a flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= access;
      pslverr_q <= access && !mapped;
      prdata_q <= 32'h0000_0000;
      if (access && !pwrite) begin
        case (paddr)
          HLK_A_CTRL: prdata_q <= {30'h0, walk_busy, health_en_q};
          HLK_A_LOGSEL: prdata_q <= {24'h0, log_sel_q};
          HLK_A_RDIDX: prdata_q <= {23'h0, rd_idx_q};
          HLK_A_RDDATA: prdata_q <= {24'h0, rd_byte};
          HLK_A_DSTATE: prdata_q <= {24'h0, dvend_q, dstate_q};
          HLK_A_POH: prdata_q <= {16'h0, poh_q};
          HLK_A_STDESC: prdata_q <= {8'h0, std_cp_q, std_stat_q, std_num_q};
          HLK_A_STLBA: prdata_q <= std_lba_q;
          HLK_A_CMD: prdata_q <= {16'h0, cmd_err_q, cmd_sts_q};
          HLK_A_INFO: prdata_q <= {3'h0, st_ptr_q, err_cnt_q, 5'h0, err_ptr_q};
          default: prdata_q <= 32'h0000_0000; // unmapped and write-only
        endcase
      end
    end
  end
  // plain settings written by software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      log_sel_q <= HLK_LOG_DIR;
      rd_idx_q <= 9'h000;
      dstate_q <= HLK_STATE_UNKNOWN;
      dvend_q <= 4'h0;
      poh_q <= 16'h0000;
      std_num_q <= 8'h00;
      std_stat_q <= 8'h00;
      std_cp_q <= 8'h00;
      std_lba_q <= 32'h0000_0000;
    end else if (ce && wr_acc) begin
      case (paddr)
        HLK_A_LOGSEL: log_sel_q <= pwdata[7:0];
        HLK_A_RDIDX: rd_idx_q <= pwdata[8:0];
        HLK_A_DSTATE: {dvend_q, dstate_q} <= pwdata[7:0];
        HLK_A_POH: poh_q <= pwdata[15:0];
        HLK_A_STDESC: {std_cp_q, std_stat_q, std_num_q} <= pwdata[23:0];
        HLK_A_STLBA: std_lba_q <= pwdata;
        default: ;
      endcase
    end
  end
  // staging byte writes: index in [6:0], data in [15:8]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < HLK_REC_BYTES; i++) stage_q[i] <= 8'h00;
    end else if (ce && wr_acc && paddr == HLK_A_STAGE) begin
      if (int'(pwdata[6:0]) < HLK_REC_BYTES) stage_q[pwdata[6:0]] <= pwdata[15:8];
    end
  end
  // error commit: overwrite next slot, count with saturation
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ERR_BYTES; i++) err_mem_q[i] <= 8'h00;
      err_ptr_q <= HLK_PTR_RESET;
      err_cnt_q <= 16'h0000;
    end else if (ce && commit_err) begin
      for (int j = 0; j < HLK_REC_BYTES; j++) begin
        err_mem_q[(int'(err_next) - 1) * HLK_REC_BYTES + j] <= rec_byte[j];
      end
      err_ptr_q <= err_next;
      if (err_cnt_q != 16'hFFFF) err_cnt_q <= err_cnt_q + 16'h0001;
    end
  end
  // self-test commit into a ring of descriptors
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < HLK_ST_DESCS; i++) begin
        st_num_q[i] <= 8'h00;
        st_stat_q[i] <= 8'h00;
        st_poh_q[i] <= 16'h0000;
        st_cp_q[i] <= 8'h00;
        st_lba_q[i] <= 32'h0000_0000;
      end
      st_ptr_q <= 5'h00;
    end else if (ce && commit_st) begin
      st_num_q[st_next - 5'h01] <= std_num_q;
      st_stat_q[st_next - 5'h01] <= std_stat_q;
      st_poh_q[st_next - 5'h01] <= poh_q;
      st_cp_q[st_next - 5'h01] <= std_cp_q;
      st_lba_q[st_next - 5'h01] <= std_lba_q;
      st_ptr_q <= st_next;
    end
  end
  // health command check: fields {cyl_hi, cyl_lo, features}
  logic [7:0] c_feat, c_lo, c_hi;
  logic c_known;
  assign c_feat = pwdata[7:0];
  assign c_lo = pwdata[15:8];
  assign c_hi = pwdata[23:16];
  always_comb begin
    case (c_feat)
      HLK_SUB_READ_DATA, HLK_SUB_READ_THR, HLK_SUB_SAVE, HLK_SUB_READ_LOG,
      HLK_SUB_WRITE_LOG, HLK_SUB_ENABLE, HLK_SUB_DISABLE,
      HLK_SUB_STATUS: c_known = 1'b1;
      default: c_known = 1'b0;
    endcase
  end
  // checks in priority order; last answer held until next command
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_sts_q <= HLK_STS_OK;
      cmd_err_q <= HLK_ERR_NONE;
      health_en_q <= HLK_EN_RESET;
    end else if (ce && cmd_wr) begin
      cmd_sts_q <= HLK_STS_FAIL;
      cmd_err_q <= HLK_ERR_ABORT;
      if (c_lo != HLK_KEY_LO || c_hi != HLK_KEY_HI || !c_known) begin
        cmd_err_q <= HLK_ERR_ABORT;
      end else if (!health_en_q && c_feat != HLK_SUB_ENABLE) begin
        cmd_err_q <= HLK_ERR_ABORT;
      end else if ((c_feat == HLK_SUB_READ_DATA || c_feat == HLK_SUB_READ_THR) &&
                   rdf_sync_q[1]) begin
        cmd_err_q <= HLK_ERR_RDFAIL;
      end else if (c_feat == HLK_SUB_SAVE && wrf_sync_q[1]) begin
        cmd_err_q <= HLK_ERR_WRFAIL;
      end else begin
        cmd_sts_q <= HLK_STS_OK;
        cmd_err_q <= HLK_ERR_NONE;
        if (c_feat == HLK_SUB_ENABLE) health_en_q <= 1'b1;
        if (c_feat == HLK_SUB_DISABLE) health_en_q <= 1'b0;
      end
    end
  end
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
endmodule

/* src/hlk_pkg.sv */
// shared constants of the health log sector keeper
// assumes an apb slave on a single 25 MHz clock domain
package hlk_pkg;
  // apb register byte offsets
  localparam logic [7:0] HLK_A_CTRL = 8'h00;
  localparam logic [7:0] HLK_A_LOGSEL = 8'h04;
  localparam logic [7:0] HLK_A_RDIDX = 8'h08;
  localparam logic [7:0] HLK_A_RDDATA = 8'h0C;
  localparam logic [7:0] HLK_A_STAGE = 8'h10;
  localparam logic [7:0] HLK_A_DSTATE = 8'h14;
  localparam logic [7:0] HLK_A_POH = 8'h18;
  localparam logic [7:0] HLK_A_STDESC = 8'h1C;
  localparam logic [7:0] HLK_A_STLBA = 8'h20;
  localparam logic [7:0] HLK_A_CMD = 8'h24;
  localparam logic [7:0] HLK_A_INFO = 8'h28;
  // ctrl bit positions
  localparam int HLK_B_COMMIT_ERR = 0;
  localparam int HLK_B_COMMIT_ST = 1;
  localparam int HLK_B_ASSEMBLE = 2;
  // sector geometry
  localparam int HLK_SECTOR_LAST = 511;
  localparam logic [8:0] HLK_OFS_CHECKSUM = 9'h1FF;
  // log addresses
  localparam logic [7:0] HLK_LOG_DIR = 8'h00;
  localparam logic [7:0] HLK_LOG_SUMMARY = 8'h01;
  localparam logic [7:0] HLK_LOG_SELFTEST = 8'h06;
  localparam logic [7:0] HLK_LOG_HOST_LO = 8'h80;
  localparam logic [7:0] HLK_LOG_HOST_HI = 8'h9F;
  localparam logic [7:0] HLK_HOST_LOG_SECTORS = 8'h10;
  localparam logic [7:0] HLK_LOG_VERSION = 8'h01;
  // summary error log layout
  localparam int HLK_ERR_RECS = 5;
  localparam int HLK_REC_BYTES = 90;
  localparam logic [8:0] HLK_OFS_REC0 = 9'h002;
  localparam logic [8:0] HLK_OFS_ERRCNT = 9'h1C4;
  localparam int HLK_OFS_ESNAP = 8'h3C;
  localparam int HLK_OFS_STATE = 8'h1B;
  localparam int HLK_OFS_LIFE = 8'h1C;
  localparam logic [2:0] HLK_PTR_RESET = 3'h5;
  // self-test log layout
  localparam int HLK_ST_DESCS = 21;
  localparam int HLK_ST_BYTES = 24;
  localparam logic [8:0] HLK_OFS_DESC0 = 9'h002;
  localparam logic [8:0] HLK_OFS_STPTR = 9'h1FC;
  localparam logic [7:0] HLK_ST_REV = 8'h01;
  // device state codes in the low nibble
  localparam logic [3:0] HLK_STATE_UNKNOWN = 4'h0;
  localparam logic [3:0] HLK_STATE_OFFLINE = 4'h4;
  localparam logic [3:0] HLK_STATE_VEND_LO = 4'hB;
  // health command keys, subcommands and answers
  localparam logic [7:0] HLK_KEY_LO = 8'h4F;
  localparam logic [7:0] HLK_KEY_HI = 8'hC2;
  localparam logic [7:0] HLK_SUB_READ_DATA = 8'hD0;
  localparam logic [7:0] HLK_SUB_READ_THR = 8'hD1;
  localparam logic [7:0] HLK_SUB_SAVE = 8'hD3;
  localparam logic [7:0] HLK_SUB_READ_LOG = 8'hD5;
  localparam logic [7:0] HLK_SUB_WRITE_LOG = 8'hD6;
  localparam logic [7:0] HLK_SUB_ENABLE = 8'hD8;
  localparam logic [7:0] HLK_SUB_DISABLE = 8'hD9;
  localparam logic [7:0] HLK_SUB_STATUS = 8'hDA;
  localparam logic [7:0] HLK_STS_OK = 8'h50;
  localparam logic [7:0] HLK_STS_FAIL = 8'h51;
  localparam logic [7:0] HLK_ERR_NONE = 8'h00;
  localparam logic [7:0] HLK_ERR_ABORT = 8'h04;
  localparam logic [7:0] HLK_ERR_RDFAIL = 8'h40;
  localparam logic [7:0] HLK_ERR_WRFAIL = 8'h01;
  localparam logic HLK_EN_RESET = 1'b1;
endpackage

/* verif/hlk_host.sv */
// apb master standing in for the host controller that reads log sectors
// assumes the keeper answers within 50 cycles; a longer wait counts a hang
`timescale 1ns/1ps
module hlk_host (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  int hangs = 0; // transfers never answered
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // one transfer: setup, then access held until pready seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) hangs++;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data must not look valid
  endtask
endmodule

/* verif/hlk_keeper_checker.sv */
// assertions on the apb face of hlk_keeper
// assumes one clock domain and a master that holds each request until pready
`timescale 1ns/1ps
module hlk_keeper_checker
  import hlk_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // first access cycle always answered one cycle later
  one_wait_a: assert property (psel && penable && !pready && ce |=> pready)
    else $error("no answer one cycle after access");
  // answer is a single-cycle pulse
  ready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("pready held too long");
  // outputs quiet outside the answer cycle
  idle_quiet_a: assert property (!pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("prdata or pslverr outside answer");
  // an answer needs an access in the cycle before
  ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable && ce))
    else $error("pready without access");
  // addresses above the map are refused with zero data
  unmapped_refuse_a: assert property (pready && paddr > HLK_A_INFO |-> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
  mapped_ok_a: assert property (pready && paddr <= HLK_A_INFO && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped address refused");
  info_range_a: assert property (
    pready && !pwrite && paddr == HLK_A_INFO |-> prdata[2:0] inside {[1:5]} && prdata[28:24] <= 5'd21)
    else $error("log pointer out of range");
  cmd_codes_a: assert property (
    pready && !pwrite && paddr == HLK_A_CMD
      |-> prdata[15:0] inside {16'h0050, 16'h0451, 16'h4051, 16'h0151})
    else $error("undefined command answer");
endmodule
bind hlk_keeper hlk_keeper_checker u_chk (.clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr,
  .pready, .prdata, .pslverr);

/* verif/hlk_keeper_tb.sv */
// self-checking bench: behavioural log model against hlk_keeper over apb
// assumes hlk_host drives the bus; ce stays high throughout
`timescale 1ns/1ps
module hlk_keeper_tb;
  import hlk_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic attr_rd_fail = 1'b0;
  logic attr_wr_fail = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int failures = 0;
  int samples_checked = 0;
  int eptr = 5; // model error pointer
  int ecnt = 0; // model error count
  int sptr = 0; // model self-test pointer
  bit en = 1'b1; // model health enable
  logic [15:0] lfsr_q = 16'h3C86;
  logic [7:0] st [90];
  logic [7:0] rec [5][90] = '{default: 8'h00};
  logic [7:0] sd [21][24] = '{default: 8'h00};
  logic [7:0] ex [512];
  logic [7:0] subs [11] = '{8'hD0, 8'hD1, 8'hD3, 8'hD5, 8'hD6, 8'hD8, 8'hD9, 8'hDA, 8'h00,
    8'hD2, 8'hFF};
  always #20 clk = ~clk;
  hlk_host host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  hlk_keeper DUT (.clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .attr_rd_fail(attr_rd_fail),
    .attr_wr_fail(attr_wr_fail), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // pseudo-random bytes from a fixed seed
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q[7:0];
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic end_of_test();
    failures += host.hangs;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, q, e);
    if (host.hangs != 0) end_of_test(); // a lost answer ends the run
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    host.xfer(1'b0, a, 32'h0, q, e);
    if (host.hangs != 0) end_of_test();
  endtask
  // expected sector image of one log, checksum last
  task automatic build(input int lg);
    int s;
    foreach (ex[i]) ex[i] = 8'h00;
    ex[0] = (lg == 0 || lg == 1 || lg == 6) ? 8'h01 : 8'h00;
    for (int a = 1; a < 256 && lg == 0; a++)
      ex[2*a] = (a == 1 || a == 6) ? 8'h01 : (a >= 128 && a < 160) ? 8'h10 : 8'h00;
    if (lg == 1) begin
      ex[1] = 8'(eptr);
      for (int r = 0; r < 5; r++) for (int b = 0; b < 90; b++) ex[2+90*r+b] = rec[r][b];
      ex[9'h1C4] = ecnt[7:0];
      ex[9'h1C5] = ecnt[15:8];
    end
    if (lg == 6) begin
      for (int n = 0; n < 21; n++) for (int b = 0; b < 24; b++) ex[2+24*n+b] = sd[n][b];
      ex[9'h1FC] = 8'(sptr);
    end
    s = 0;
    for (int i = 0; i < 511; i++) s += ex[i];
    ex[511] = 8'(-s);
  endtask
  // select a log, wait out the checksum walk, compare every byte
  task automatic check_sector(input int lg);
    logic [31:0] q;
    int n;
    build(lg);
    wr(HLK_A_LOGSEL, 32'(lg));
    n = 0;
    do begin
      rd(HLK_A_CTRL, q);
      n++;
    end while (q[1] !== 1'b0 && n < 300);
    if (n >= 300) begin
      failures++;
      end_of_test();
    end
    for (int i = 0; i < 512; i++) begin
      wr(HLK_A_RDIDX, 32'(i));
      rd(HLK_A_RDDATA, q);
      check(q, {24'h0, ex[i]});
    end
  endtask
  task automatic commit_err();
    logic [7:0] sv;
    logic [15:0] poh;
    for (int b = 0; b < 90; b++) begin
      st[b] = rnd();
      wr(HLK_A_STAGE, {16'h0, st[b], 1'b0, 7'(b)});
    end
    wr(HLK_A_STAGE, {16'h0, 8'hEE, 8'd90}); // out of range, ignored
    sv = rnd();
    poh = {rnd(), rnd()};
    wr(HLK_A_DSTATE, {24'h0, sv});
    wr(HLK_A_POH, {16'h0, poh});
    wr(HLK_A_CTRL, 32'h1);
    eptr = (eptr == 5) ? 1 : eptr + 1;
    ecnt++;
    rec[eptr-1] = st;
    rec[eptr-1][8'h57] = {sv[7:4], (sv[3:0] inside {[5:10]}) ? 4'h0 : sv[3:0]};
    rec[eptr-1][8'h58] = poh[7:0];
    rec[eptr-1][8'h59] = poh[15:8];
  endtask
  task automatic commit_st();
    logic [71:0] t;
    t = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    wr(HLK_A_STDESC, {8'h0, t[39:32], t[15:0]});
    wr(HLK_A_STLBA, t[71:40]);
    wr(HLK_A_POH, {16'h0, t[31:16]});
    wr(HLK_A_CTRL, 32'h2);
    sptr = (sptr == 21) ? 1 : sptr + 1;
    for (int b = 0; b < 9; b++) sd[sptr-1][b] = t[8*b +: 8];
  endtask
  // issue a health command and compare the answer with the model
  task automatic cmd(input logic [7:0] f, input logic [15:0] key);
    logic [31:0] q;
    logic [15:0] w;
    wr(HLK_A_CMD, {8'h0, key, f});
    if (key != {HLK_KEY_HI, HLK_KEY_LO} ||
        !(f inside {8'hD0, 8'hD1, 8'hD3, 8'hD5, 8'hD6, 8'hD8, 8'hD9, 8'hDA})) w = 16'h0451;
    else if (!en && f != HLK_SUB_ENABLE) w = 16'h0451;
    else if ((f == 8'hD0 || f == 8'hD1) && attr_rd_fail) w = 16'h4051;
    else if (f == 8'hD3 && attr_wr_fail) w = 16'h0151;
    else begin
      w = 16'h0050;
      en = (f == HLK_SUB_ENABLE) ? 1'b1 : (f == HLK_SUB_DISABLE) ? 1'b0 : en;
    end
    rd(HLK_A_CMD, q);
    check(q, {16'h0, w});
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd(HLK_A_CTRL, q);
    check(q & 32'h1, 32'h1);
    host.xfer(1'b0, 8'h40, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    check_sector(0);
    check_sector(6);
    repeat (6) commit_err();
    repeat (22) commit_st();
    check_sector(1);
    check_sector(6);
    rd(HLK_A_INFO, q);
    check(q, {3'h0, 5'(sptr), 16'(ecnt), 5'h0, 3'(eptr)});
    for (int p = 0; p < 2; p++) begin
      foreach (subs[i]) cmd(subs[i], {HLK_KEY_HI, HLK_KEY_LO});
      cmd(HLK_SUB_DISABLE, {HLK_KEY_HI, HLK_KEY_LO});
    end
    cmd(HLK_SUB_ENABLE, {HLK_KEY_HI, HLK_KEY_LO});
    cmd(HLK_SUB_STATUS, {HLK_KEY_HI, 8'h4E});
    cmd(HLK_SUB_STATUS, {8'hC3, HLK_KEY_LO});
    @(posedge clk);
    attr_rd_fail <= 1'b1;
    attr_wr_fail <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (subs[i]) cmd(subs[i], {HLK_KEY_HI, HLK_KEY_LO});
    // second reset in mid-run: log pointers and error count must return to their reset values
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(HLK_A_INFO, q);
    check(q, {3'h0, 5'h00, 16'h0000, 5'h0, HLK_PTR_RESET});
    end_of_test();
  end
endmodule
